// ---- include/rsc_pkg.sv ----
// constants, register map and carriers for the reset source controller
// assumes a 20 MHz system clock and an AXI4-Lite register bus
package rsc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MCD_TIME_US = 100;
  localparam int MCD_CYCLES = (CLK_HZ / 1_000_000) * MCD_TIME_US;
  localparam int RTC_MIN_HZ = 20_000;
  localparam int RTC_FAIL_CYCLES = CLK_HZ / RTC_MIN_HZ;
  localparam int WDT_DIV = 12;
  localparam int WDT_TICKS_DEF = 65535;
  localparam int RST_HOLD_DEF = 16;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CAUSE_IDX = 12'h0EF;
  localparam logic [ADDR_W-1:0] WDT_CTRL_IDX = 12'h0F0;

  localparam int BIT_PIN = 0;
  localparam int BIT_SUPPLY = 1;
  localparam int BIT_MCD = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_SW = 4;
  localparam int BIT_CMP = 5;
  localparam int BIT_FLASH = 6;
  localparam int BIT_RTC = 7;
  localparam int BIT_WDT_EN = 0;
  localparam int BIT_WDT_KICK = 1;

  localparam logic [7:0] CAUSE_POR = 8'h02;
  localparam logic EN_SUPPLY_POR = 1'b1;
  localparam logic WDT_EN_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {RSC_RUN, RSC_HOLD} rsc_state_e;

  typedef struct packed {
    logic wr_enable;
    logic xdata_wr;
    logic code_rd;
    logic branch_fetch;
    logic wr_erase;
    logic secure_viol;
    logic mon_on;
    logic [15:0] addr;
    logic [15:0] lock_addr;
  } rsc_flash_s;

  typedef struct packed {
    logic alarm_en;
    logic osc_det_en;
    logic [31:0] timer;
    logic [31:0] alarm;
  } rsc_rtc_s;
endpackage

// ---- rtl/rsc_sync.sv ----
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level from outside the clock domain
`timescale 1ns/10ps
module rsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsc_sync_s;
  rsc_sync_s r, n;

  always_comb begin
    n.s1 = din;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout = r.s2;
endmodule

// ---- rtl/rsc_stuck_det.sv ----
// detector that pulses when a probe holds one level for LIMIT cycles
// assumes the probe is already synchronised to clk_sys
`timescale 1ns/10ps
module rsc_stuck_det #(
  parameter int LIMIT = 2000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic enable,
  input wire logic probe,
  output logic timeout
);
  localparam int CW = $clog2(LIMIT + 1);
  typedef struct packed {
    logic last;
    logic [CW-1:0] cnt;
    logic timeout;
  } rsc_stuck_s;
  rsc_stuck_s r, n;

  generate
    if (LIMIT < 2) begin : g_chk
      $error("rsc_stuck_det: LIMIT below 2");
    end
  endgenerate

  always_comb begin
    n = r;
    n.last = probe;
    n.timeout = 1'b0;
    if (!enable || probe != r.last) begin
      n.cnt = '0;
    end else if (r.cnt == CW'(LIMIT - 1)) begin
      n.timeout = 1'b1;
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign timeout = r.timeout;

  a_stuck_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    !enable |=> !timeout)
    else $error("stuck detector fired while disabled");
endmodule

// ---- rtl/rsc_top.sv ----
// reset source controller with AXI4-Lite register slave
// assumes rstn is the power-on reset and sys_rst_n feeds the rest of the chip
`timescale 1ns/10ps
module rsc_top #(
  parameter int WDT_TICKS = rsc_pkg::WDT_TICKS_DEF,
  parameter int RST_HOLD = rsc_pkg::RST_HOLD_DEF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_rst_pin_n,
  input wire logic supply_low,
  input wire logic cmp_out,
  input wire logic system_clock_probe,
  input wire logic rtc_clk_probe,
  input wire logic low_power,
  input wire rsc_pkg::rsc_flash_s flash,
  input wire rsc_pkg::rsc_rtc_s rtc,
  output logic sys_rst_n,
  output logic flash_block
);
  localparam int HW = $clog2(RST_HOLD + 1);
  localparam int DW = $clog2(rsc_pkg::WDT_DIV);

  generate
    if (RST_HOLD < 1 || RST_HOLD > 255 || WDT_TICKS < 2 || WDT_TICKS > 65535) begin : g_chk
      $error("rsc_top: RST_HOLD or WDT_TICKS out of range");
    end
  endgenerate

  typedef struct packed {
    rsc_pkg::rsc_state_e state;
    logic [HW-1:0] hold_cnt;
    logic [7:0] cause;
    logic en_rtc;
    logic en_cmp;
    logic en_mcd;
    logic en_supply;
    logic wdt_en;
    logic [DW-1:0] wdt_div;
    logic [15:0] wdt_cnt;
    logic sys_rst_n;
    logic flash_block;
    logic aw_got;
    logic [rsc_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsc_top_s;
  rsc_top_s r, n;

  function automatic logic rsc_hit(input logic [rsc_pkg::ADDR_W-1:0] a, input logic [rsc_pkg::ADDR_W-1:0] idx);
    rsc_hit = (a == rsc_pkg::ADDR_W'({idx, 2'b00}));
  endfunction

  logic [4:0] sync_in, sync_out;
  logic pin_req, supply_s, cmp_s, sclk_s, rclk_s;
  logic mcd_to, rtc_fail, alarm_hit, flash_err, wdt_tick, wdt_ovf;
  logic wr_fire, sw_req;
  logic [7:0] src;

  // pin and comparator enter inverted so the synchroniser's reset level means no request
  assign sync_in = {rtc_clk_probe, system_clock_probe, !cmp_out, supply_low, !ext_rst_pin_n};

  rsc_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(sync_in),
    .dout(sync_out)
  );

  assign pin_req = sync_out[0];
  assign supply_s = sync_out[1];
  assign cmp_s = sync_out[2];
  assign sclk_s = sync_out[3];
  assign rclk_s = sync_out[4];

  // clock detector is parked in suspend and sleep, enable bit untouched
  rsc_stuck_det #(.LIMIT(rsc_pkg::MCD_CYCLES)) u_mcd (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .enable(r.en_mcd && !low_power),
    .probe(sclk_s),
    .timeout(mcd_to)
  );

  // not gated by low_power so the rtc path keeps working asleep
  rsc_stuck_det #(.LIMIT(rsc_pkg::RTC_FAIL_CYCLES)) u_rtc_fail (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .enable(rtc.osc_det_en),
    .probe(rclk_s),
    .timeout(rtc_fail)
  );

  assign alarm_hit = rtc.alarm_en && (rtc.timer == rtc.alarm);

  assign flash_err = (flash.wr_enable && flash.xdata_wr && flash.addr > flash.lock_addr)
    || (flash.code_rd && flash.addr > flash.lock_addr)
    || (flash.branch_fetch && flash.addr > flash.lock_addr)
    || flash.secure_viol
    || (flash.wr_erase && !flash.mon_on);

  assign wdt_tick = (r.wdt_div == DW'(rsc_pkg::WDT_DIV - 1));
  assign wdt_ovf = r.wdt_en && !low_power && wdt_tick && r.wdt_cnt == 16'(WDT_TICKS - 1);

  assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
  assign sw_req = wr_fire && r.w_lane0 && rsc_hit(r.aw_addr, rsc_pkg::CAUSE_IDX)
    && r.w_data[rsc_pkg::BIT_SW];

  always_comb begin
    src = 8'h00;
    src[rsc_pkg::BIT_PIN] = pin_req;
    src[rsc_pkg::BIT_SUPPLY] = supply_s && r.en_supply;
    src[rsc_pkg::BIT_MCD] = mcd_to;
    src[rsc_pkg::BIT_WDT] = wdt_ovf;
    src[rsc_pkg::BIT_SW] = sw_req;
    src[rsc_pkg::BIT_CMP] = r.en_cmp && cmp_s;
    src[rsc_pkg::BIT_FLASH] = flash_err;
    src[rsc_pkg::BIT_RTC] = r.en_rtc && (rtc_fail || alarm_hit);
  end

  always_comb begin
    n = r;
    n.flash_block = flash_err;
    // write address and data are taken independently, answered together
    if (s_axi_awvalid && r.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata[7:0];
      n.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = rsc_pkg::RESP_OKAY;
      if (rsc_hit(r.aw_addr, rsc_pkg::CAUSE_IDX)) begin
        if (r.w_lane0) begin
          n.en_rtc = r.w_data[rsc_pkg::BIT_RTC];
          n.en_cmp = r.w_data[rsc_pkg::BIT_CMP];
          n.en_mcd = r.w_data[rsc_pkg::BIT_MCD];
          n.en_supply = r.w_data[rsc_pkg::BIT_SUPPLY];
        end
      end else if (rsc_hit(r.aw_addr, rsc_pkg::WDT_CTRL_IDX)) begin
        if (r.w_lane0) begin
          n.wdt_en = r.w_data[rsc_pkg::BIT_WDT_EN];
          if (r.w_data[rsc_pkg::BIT_WDT_KICK]) begin
            n.wdt_cnt = 16'h0000;
          end
        end
      end else begin
        n.bresp = rsc_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;

    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp = rsc_pkg::RESP_OKAY;
      if (rsc_hit(s_axi_araddr, rsc_pkg::CAUSE_IDX)) begin
        n.rdata = {24'h000000, r.cause};
      end else if (rsc_hit(s_axi_araddr, rsc_pkg::WDT_CTRL_IDX)) begin
        n.rdata = {r.wdt_cnt, 15'h0000, r.wdt_en};
      end else begin
        n.rdata = 32'h00000000;
        n.rresp = rsc_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;

    // divider and counter halt in low power, enable bit is left alone
    if (r.wdt_en && !low_power) begin
      n.wdt_div = wdt_tick ? '0 : r.wdt_div + 1'b1;
      if (wdt_tick && !(wr_fire && n.wdt_cnt == 16'h0000)) begin
        n.wdt_cnt = r.wdt_cnt + 16'h0001;
      end
    end

    unique case (r.state)
      rsc_pkg::RSC_RUN: begin
        // chip runs whenever no source is pending, power-on release included
        n.sys_rst_n = 1'b1;
        if (|src) begin
          n.state = rsc_pkg::RSC_HOLD;
          n.hold_cnt = '0;
          n.cause = src & (~src + 8'h01);
          n.sys_rst_n = 1'b0;
          n.wdt_en = rsc_pkg::WDT_EN_RST;
          n.wdt_div = '0;
          n.wdt_cnt = 16'h0000;
        end
      end
      rsc_pkg::RSC_HOLD: begin
        n.wdt_en = rsc_pkg::WDT_EN_RST;
        n.wdt_div = '0;
        n.wdt_cnt = 16'h0000;
        // a held pin keeps the chip in reset; the flag is set on entry to hold
        if (r.hold_cnt != HW'(RST_HOLD - 1)) begin
          n.hold_cnt = r.hold_cnt + 1'b1;
        end else if (!pin_req) begin
          n.state = rsc_pkg::RSC_RUN;
          n.sys_rst_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.state <= rsc_pkg::RSC_RUN;
      r.cause <= rsc_pkg::CAUSE_POR;
      r.en_supply <= rsc_pkg::EN_SUPPLY_POR;
      r.wdt_en <= rsc_pkg::WDT_EN_RST;
      r.sys_rst_n <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign sys_rst_n = r.sys_rst_n;
  assign flash_block = r.flash_block;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_run_event(int b);
    r.state == rsc_pkg::RSC_RUN && src[b] && (src & ((8'h01 << b) - 8'h01)) == 8'h00;
  endsequence

  sequence s_enter_hold(int b);
    !sys_rst_n && r.cause == (8'h01 << b) && r.state == rsc_pkg::RSC_HOLD;
  endsequence

  a_sw_force: assert property (s_run_event(rsc_pkg::BIT_SW) |=> s_enter_hold(rsc_pkg::BIT_SW))
    else $error("software force did not reset with bit 4");
  a_flash_cause: assert property (s_run_event(rsc_pkg::BIT_FLASH) |=> s_enter_hold(rsc_pkg::BIT_FLASH))
    else $error("flash error did not reset with bit 6");
  a_rtc_cause: assert property (s_run_event(rsc_pkg::BIT_RTC) |=> s_enter_hold(rsc_pkg::BIT_RTC))
    else $error("rtc event did not reset with bit 7");
  a_wdt_expire: assert property (s_run_event(rsc_pkg::BIT_WDT) |=> s_enter_hold(rsc_pkg::BIT_WDT))
    else $error("watchdog overflow did not reset with bit 3");
  a_flash_block: assert property (flash_err |=> flash_block && !sys_rst_n)
    else $error("flash error not blocked");
  a_cause_onehot: assert property ($onehot(r.cause))
    else $error("cause register not one-hot");
  a_hold_length: assert property ($rose(sys_rst_n) && $past(r.state) == rsc_pkg::RSC_HOLD
    |-> $past(r.hold_cnt) == HW'(RST_HOLD - 1) && !$past(pin_req))
    else $error("reset released early");
  a_pin_holds: assert property (pin_req |=> !sys_rst_n)
    else $error("pin request did not hold reset");
  a_wdt_rearm: assert property ($fell(sys_rst_n) |-> r.wdt_en && r.wdt_cnt == 16'h0000 ##1 r.wdt_en)
    else $error("watchdog not re-enabled by reset");
  a_wdt_sleep: assert property (low_power && !wr_fire && r.state == rsc_pkg::RSC_RUN && src == 8'h00
    |=> $stable(r.wdt_cnt) && $stable(r.wdt_en))
    else $error("watchdog moved in low power");
  a_mcd_sleep: assert property (low_power [*2] |-> !mcd_to)
    else $error("clock detector fired in low power");
  a_pin_cause: assert property (s_run_event(rsc_pkg::BIT_PIN) |=> s_enter_hold(rsc_pkg::BIT_PIN))
    else $error("pin request did not reset with bit 0");
  a_supply_cause: assert property (s_run_event(rsc_pkg::BIT_SUPPLY) |=> s_enter_hold(rsc_pkg::BIT_SUPPLY))
    else $error("supply monitor did not reset with bit 1");
  a_mcd_cause: assert property (s_run_event(rsc_pkg::BIT_MCD) |=> s_enter_hold(rsc_pkg::BIT_MCD))
    else $error("clock detector did not reset with bit 2");
  a_cmp_cause: assert property (s_run_event(rsc_pkg::BIT_CMP) |=> s_enter_hold(rsc_pkg::BIT_CMP))
    else $error("comparator did not reset with bit 5");
  a_run_release: assert property (r.state == rsc_pkg::RSC_RUN && src == 8'h00 |=> sys_rst_n)
    else $error("reset held with no source pending");
  a_wdt_div: assert property (r.wdt_en && !low_power && r.state == rsc_pkg::RSC_RUN
    && src == 8'h00 && !wdt_tick |=> r.wdt_div == $past(r.wdt_div) + 1'b1)
    else $error("watchdog prescaler did not advance");
  a_no_block: assert property (!flash_err |=> !flash_block)
    else $error("flash access blocked without an error");
  a_rtc_asleep: assert property (low_power && r.state == rsc_pkg::RSC_RUN && src == 8'h80
    |=> !sys_rst_n && r.cause == 8'h80)
    else $error("rtc event ignored in low power");
endmodule

// ---- testbench/rsc_src_model.sv ----
// partner model: the watched system clock and rtc oscillator probes
// assumes clk_sys from the bench; a stop input freezes its probe at its level
`timescale 1ns/10ps
module rsc_src_model (
  input wire logic clk_sys,
  input wire logic stop_sys,
  input wire logic stop_rtc,
  output logic system_clock_probe,
  output logic rtc_clk_probe
);
  logic [3:0] div_reg;
  initial begin
    system_clock_probe = 1'b0;
    rtc_clk_probe = 1'b0;
    div_reg = 4'h0;
  end
  always @(posedge clk_sys) begin
    div_reg <= div_reg + 4'h1;
    if (!stop_sys) begin
      system_clock_probe <= ~system_clock_probe;
    end
    // rtc toggles every 16 cycles, far below the 1000-cycle failure limit
    if (!stop_rtc && div_reg == 4'hF) begin
      rtc_clk_probe <= ~rtc_clk_probe;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the reset source controller
// assumes rsc_pkg is compiled first; drives AXI4-Lite and the reset sources
`timescale 1ns/10ps
module tb;
  localparam int TICKS = 8;
  localparam logic [11:0] CAUSE_A = {rsc_pkg::CAUSE_IDX[9:0], 2'b00};
  localparam logic [11:0] WDT_A = {rsc_pkg::WDT_CTRL_IDX[9:0], 2'b00};
  logic clk_sys, rstn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] bresp, rresp, wresp;
  logic pin_n, sup_low, cmp, lp, stop_sys, stop_rtc, sys_probe, rtc_probe, sys_rst_n, fblk;
  rsc_pkg::rsc_flash_s flash;
  rsc_pkg::rsc_rtc_s rtc;
  int errors, tests_run, cycles;

  rsc_top #(.WDT_TICKS(TICKS), .RST_HOLD(2)) rsc_top_inst (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_rst_pin_n(pin_n),
    .supply_low(sup_low), .cmp_out(cmp), .system_clock_probe(sys_probe), .rtc_clk_probe(rtc_probe),
    .low_power(lp), .flash(flash), .rtc(rtc), .sys_rst_n(sys_rst_n), .flash_block(fblk));

  rsc_src_model rsc_src_model_inst (.clk_sys(clk_sys), .stop_sys(stop_sys), .stop_rtc(stop_rtc),
    .system_clock_probe(sys_probe), .rtc_clk_probe(rtc_probe));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    awa <= a;
    awv <= 1'b1;
    wd <= {24'h000000, d};
    wv <= 1'b1;
    br <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && awr) begin
        aw_done = 1'b1;
        awv <= 1'b0;
      end
      if (!w_done && wr) begin
        w_done = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge clk_sys);
    wresp = bresp;
    br <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk_sys); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk_sys);
    d = rd;
    r = rresp;
    rr <= 1'b0;
  endtask

  task automatic wait_low();
    while (sys_rst_n !== 1'b0) @(posedge clk_sys);
  endtask

  // waits out the system reset, stops the watchdog, then reads the cause flags
  task automatic check_cause(input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    while (sys_rst_n !== 1'b1) @(posedge clk_sys);
    axi_write(WDT_A, 8'h00);
    check("bresp", {30'h0, rsc_pkg::RESP_OKAY}, {30'h0, wresp});
    axi_read(CAUSE_A, d, r);
    check("cause", {24'h000000, exp}, d);
  endtask

  task automatic test_por();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(WDT_A, d, r);
    check("wdt_en", 32'h1, {31'h0, d[0]});
    axi_read(CAUSE_A, d, r);
    check("por_flag", 32'h1, {31'h0, d[1]});
    axi_read(12'h000, d, r);
    check("unmapped_resp", {30'h0, rsc_pkg::RESP_SLVERR}, {30'h0, r});
    check("unmapped_data", 32'h0, d);
    axi_write(12'h000, 8'h00);
    check("unmapped_bresp", {30'h0, rsc_pkg::RESP_SLVERR}, {30'h0, wresp});
    axi_write(WDT_A, 8'h00);
  endtask

  task automatic test_pin();
    logic [31:0] d;
    logic [1:0] r;
    pin_n <= 1'b0;
    wait_low();
    repeat (5) @(posedge clk_sys);
    check("pin_hold", 32'h0, {31'h0, sys_rst_n});
    pin_n <= 1'b1;
    check_cause(8'h01);
    // flag-only bits ignore writes
    axi_write(CAUSE_A, 8'h4B);
    axi_read(CAUSE_A, d, r);
    check("ro_bits", 32'h1, d);
  endtask

  task automatic test_wdt();
    int n;
    bit quiet;
    axi_write(WDT_A, 8'h03);
    n = 0;
    while (sys_rst_n === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    check("wdt_window", 32'h1, {31'h0, n >= (TICKS - 2) * 12 && n <= TICKS * 12});
    check_cause(8'h08);
    axi_write(WDT_A, 8'h03);
    lp <= 1'b1;
    quiet = 1'b1;
    repeat (200) begin
      @(posedge clk_sys);
      if (sys_rst_n !== 1'b1) quiet = 1'b0;
    end
    check("wdt_lp_off", 32'h1, {31'h0, quiet});
    lp <= 1'b0;
    wait_low();
    check_cause(8'h08);
  endtask

  task automatic test_flash();
    rsc_pkg::rsc_flash_s f;
    // the last pass is a data write above the lock with write enable off: no reset
    for (int k = 0; k < 6; k++) begin
      f = '0;
      f.wr_enable = (k != 5);
      f.mon_on = (k != 4);
      f.lock_addr = 16'h3FFF;
      f.addr = (k < 3 || k == 5) ? 16'h4000 : 16'h0100;
      f.xdata_wr = (k == 0) || (k == 5);
      f.code_rd = (k == 1) || (k == 3);
      f.branch_fetch = (k == 2);
      f.secure_viol = (k == 3);
      f.wr_erase = (k == 4);
      @(posedge clk_sys);
      flash <= f;
      @(posedge clk_sys);
      flash <= '0;
      #1;
      check("flash_block", {31'h0, k != 5}, {31'h0, fblk});
      if (k == 5) begin
        check("flash_legal", 32'h1, {31'h0, sys_rst_n});
      end else begin
        wait_low();
        check_cause(8'h40);
      end
    end
  endtask

  task automatic test_sources();
    axi_write(CAUSE_A, 8'h02);
    sup_low <= 1'b1;
    wait_low();
    sup_low <= 1'b0;
    check_cause(8'h02);
    axi_write(CAUSE_A, 8'h22);
    cmp <= 1'b0;
    wait_low();
    cmp <= 1'b1;
    check_cause(8'h20);
    axi_write(CAUSE_A, 8'h26);
    stop_sys <= 1'b1;
    wait_low();
    stop_sys <= 1'b0;
    check_cause(8'h04);
  endtask

  task automatic test_rtc_sw();
    axi_write(CAUSE_A, 8'hA6);
    lp <= 1'b1;
    rtc.timer <= 32'h00001234;
    rtc.alarm <= 32'h00001234;
    rtc.alarm_en <= 1'b1;
    wait_low();
    rtc.alarm_en <= 1'b0;
    lp <= 1'b0;
    check_cause(8'h80);
    rtc.osc_det_en <= 1'b1;
    stop_rtc <= 1'b1;
    wait_low();
    stop_rtc <= 1'b0;
    rtc.osc_det_en <= 1'b0;
    check_cause(8'h80);
    axi_write(CAUSE_A, 8'hB6);
    wait_low();
    check_cause(8'h10);
  endtask

  initial begin
    {rstn, awv, wv, br, arv, rr, sup_low, lp, stop_sys, stop_rtc} = '0;
    {pin_n, cmp} = 2'b11;
    awa = 12'h000;
    ara = 12'h000;
    wd = 32'h0;
    flash = '0;
    rtc = '0;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    test_por();
    test_pin();
    test_wdt();
    test_flash();
    test_sources();
    test_rtc_sw();
    finish_test();
  end
endmodule
